// >>> pmr_regs.sv
`timescale 1ns/1ps
// Contract
// (R1) Identifier is 32 read-only bits in registers 2 and 3, unchanged by reset.
// (R2) Register 3 holds company bits 15-10, model 9-4, revision 3-0.
// (R3) Advertisement word goes to the partner; default advertises four modes plus selector.
// (R4) Next-page request bit tells the partner next pages are wanted.
// (R5) Acknowledge bit is read-only, driven by negotiation on partner word receipt.
// (R6) Remote-fault bit is carried in advertised frames.
// (R7) Only supported ability modes may be set by software.
// (R8) Register 5 mirrors the partner word, read-only, reset zero.
// (R9) Config one: link detect off, transmitter off, transmitter sleep controls.
// (R10) Scrambler bypass affects both scrambler and descrambler.
// (R11) Plain idle reject blocks negotiation with unscrambled-idle partners.
// (R12) Equalizer off disables equalizer, zero length; on only at 100 Mbps.
// (R13) Software writes zero to reserved bits of config one.
// (R14) Config two upper byte reads ones; polarity fix off disables correction.
// (R15) Babble check off disables jabber detection.
// (R16) Multi register access bit enables multiple-register access.
// (R17) Line pulse bit enables interrupt pulses on idle management line.
// (R18) Change flag reads one when any status bit changed since last read.
// (R19) Status latches link, sync, code, delimiter, polarity, babble events.
// (R20) Speed result one at 100 Mbps; duplex result one at full duplex.
// (R21) Mask bits suppress matching interrupts; all ten reset to one.
// (R22) Registers reached over management frames, also while isolated.
// (R23) Latched status holds until read, then clears if condition gone.
// (R24) Interrupt rises on unmasked change, drops after status read.
module pmr_regs
    import pmr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        mgmt_valid,
    input  wire logic        mgmt_write,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_rvalid,
    input  wire logic        an_ack_in,
    input  wire logic        an_partner_load,
    input  wire logic [15:0] an_partner_word,
    input  wire logic        ev_link_lost,
    input  wire logic        ev_desc_unlocked,
    input  wire logic        ev_bad_code_group,
    input  wire logic        ev_start_delim_error,
    input  wire logic        ev_end_delim_error,
    input  wire logic        ev_polarity_flipped,
    input  wire logic        ev_babble_detect,
    input  wire logic        speed_100,
    input  wire logic        duplex_full,
    output logic      [15:0] adv_word,
    output logic             next_page_request,
    output logic             remote_fault_adv,
    output logic             link_detect_off,
    output logic             tp_tx_off,
    output logic             tp_tx_sleep,
    output logic             scrambler_bypass,
    output logic             plain_idle_reject,
    output logic             equalizer_off,
    output logic             equalizer_on,
    output logic             polarity_fix_off,
    output logic             babble_check_off,
    output logic             multi_register_access,
    output logic             mgmt_line_irq_pulse,
    output logic             irq_pending
);
    import pmr_pkg::*;

    typedef struct packed {
        logic [15:0] adv;
        logic [15:0] partner;
        logic [15:0] cfg1;
        logic [15:0] cfg2;
        logic [15:0] mask;
        logic [15:0] fact;
        logic        change;
        logic        irq;
        logic [15:0] rdata;
        logic        rvalid;
    } pmr_state_s;

    pmr_state_s st_reg;
    pmr_state_s st_next;

    logic        wr_en;
    logic        rd_stat;
    logic [8:0]  cond;
    logic [8:0]  latched;
    logic [9:0]  stat_bits;
    logic [9:0]  stat_prev_reg;
    logic [9:0]  changed;
    logic [15:0] stat_word;

    // Writable-bit merge, used for every writable register except the factory register, which takes the whole word.
    function automatic logic [15:0] pmr_merge(input logic [15:0] old, input logic [15:0] wd,
                                              input logic [15:0] wm);
        pmr_merge = (old & ~wm) | (wd & wm);
    endfunction

    assign wr_en   = mgmt_valid && mgmt_write; // see (R22)
    assign rd_stat = mgmt_valid && !mgmt_write && (mgmt_addr == PMR_EVENT_STATUS);

    // Event conditions; babble detection is gated by the disable bit.
    assign cond = {ev_link_lost, ev_desc_unlocked, ev_bad_code_group, ev_start_delim_error,
                   ev_end_delim_error, ev_polarity_flipped,
                   ev_babble_detect && !st_reg.cfg2[PMR_C2_BABOFF], // see (R15)
                   speed_100, duplex_full}; // see (R19)

    pmr_event_latch u_latch (
        .clk      (clk),
        .rst_n    (rst_n),
        .cond     (cond),
        .rd_clear (rd_stat),
        .latched  (latched)
    );

    // Speed and duplex show the present mode directly.
    assign stat_bits = {1'b0, latched[8:2], speed_100, duplex_full}; // see (R20)
    assign changed   = stat_bits ^ stat_prev_reg;
    assign stat_word = {st_reg.change, stat_bits[8:0], 6'h00};

    // Previous status snapshot for change detection.
    // A read takes the flags that were latched and still hold their condition, so the clear itself is no change.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_prev_reg <= PMR_STAT_RESET[15:6];
        end else if (rd_stat) begin
            stat_prev_reg <= {1'b0, latched[8:2] & cond[8:2], speed_100, duplex_full}; // see (R18)
        end else begin
            stat_prev_reg <= stat_bits;
        end
    end

    // Register writes, partner capture, change flag, interrupt and read data.
    always_comb begin
        st_next        = st_reg;
        st_next.rvalid = mgmt_valid && !mgmt_write;
        if (an_partner_load) begin
            st_next.partner = an_partner_word; // see (R8)
        end
        if (wr_en) begin
            case (mgmt_addr)
                PMR_ADVERTISE: begin
                    st_next.adv = pmr_merge(st_reg.adv, mgmt_wdata, PMR_ADV_WMASK); // see (R7)
                end
                PMR_CONFIG_ONE: begin
                    st_next.cfg1 = pmr_merge(st_reg.cfg1, mgmt_wdata, PMR_CFG1_WMASK); // see (R9)
                end
                PMR_CONFIG_TWO: begin
                    st_next.cfg2 = pmr_merge(st_reg.cfg2, mgmt_wdata, PMR_CFG2_WMASK); // see (R14)
                end
                PMR_EVENT_MASK: begin
                    st_next.mask = pmr_merge(st_reg.mask, mgmt_wdata, PMR_MASK_WMASK); // see (R21)
                end
                PMR_FACTORY: begin
                    st_next.fact = mgmt_wdata;
                end
                default: begin
                    st_next.fact = st_reg.fact;
                end
            endcase
        end
        // A change in the same cycle as the read wins over the clear.
        if (rd_stat) begin
            st_next.change = 1'b0;
            st_next.irq    = 1'b0; // see (R24)
        end
        if (|changed[8:0]) begin
            st_next.change = 1'b1; // see (R18)
        end
        if (|(changed[8:0] & ~st_reg.mask[14:6]) || ((|changed[8:0]) && !st_reg.mask[15])) begin
            st_next.irq = 1'b1; // see (R24)
        end
        // Read data mux.
        case (mgmt_addr)
            PMR_IDENT_HIGH:   st_next.rdata = PMR_ID_HIGH_VAL; // see (R1)
            PMR_IDENT_LOW:    st_next.rdata = {PMR_ID_OUI_VAL, PMR_ID_MODEL, PMR_ID_REV}; // see (R2)
            PMR_ADVERTISE:    st_next.rdata = {st_reg.adv[15], an_ack_in, st_reg.adv[13:0]}; // see (R5)
            PMR_PARTNER:      st_next.rdata = st_reg.partner;
            PMR_CONFIG_ONE:   st_next.rdata = st_reg.cfg1;
            PMR_CONFIG_TWO:   st_next.rdata = st_reg.cfg2 | PMR_CFG2_RESET; // see (R14)
            PMR_EVENT_STATUS: st_next.rdata = stat_word;
            PMR_EVENT_MASK:   st_next.rdata = st_reg.mask;
            PMR_FACTORY:      st_next.rdata = st_reg.fact;
            default:          st_next.rdata = 16'h0000;
        endcase
    end

    // State register; identifiers are constants so any reset leaves them as they were.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.adv     <= PMR_ADV_RESET; // see (R3)
            st_reg.cfg1    <= PMR_CFG1_RESET;
            st_reg.cfg2    <= PMR_CFG2_RESET;
            st_reg.mask    <= PMR_MASK_RESET; // see (R21)
            st_reg.fact    <= PMR_FACT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Control outputs steered by the written registers.
    assign adv_word              = {st_reg.adv[15], an_ack_in, st_reg.adv[13:0]}; // see (R3)
    assign next_page_request     = st_reg.adv[PMR_ADV_NP]; // see (R4)
    assign remote_fault_adv      = st_reg.adv[PMR_ADV_RF]; // see (R6)
    assign link_detect_off       = st_reg.cfg1[PMR_C1_LNKOFF]; // see (R9)
    assign tp_tx_off             = st_reg.cfg1[PMR_C1_TXOFF];
    assign tp_tx_sleep           = st_reg.cfg1[PMR_C1_TXSLP];
    assign scrambler_bypass      = st_reg.cfg1[PMR_C1_BYP]; // see (R10)
    assign plain_idle_reject     = st_reg.cfg1[PMR_C1_IDLE]; // see (R11)
    assign equalizer_off         = st_reg.cfg1[PMR_C1_EQOFF]; // see (R12)
    assign equalizer_on          = !st_reg.cfg1[PMR_C1_EQOFF] && speed_100; // see (R12)
    assign polarity_fix_off      = st_reg.cfg2[PMR_C2_POLOFF];
    assign babble_check_off      = st_reg.cfg2[PMR_C2_BABOFF]; // see (R15)
    assign multi_register_access = st_reg.cfg2[PMR_C2_MULTI]; // see (R16)
    assign mgmt_line_irq_pulse   = st_reg.cfg2[PMR_C2_IRQP] && st_reg.irq; // see (R17)
    assign irq_pending           = st_reg.irq;
    assign mgmt_rdata            = st_reg.rdata;
    assign mgmt_rvalid           = st_reg.rvalid;

    // Assertions.
    a_ident_const: assert property (@(posedge clk) disable iff (!rst_n) // see (R2)
        mgmt_rvalid && $past(mgmt_addr) == PMR_IDENT_LOW |-> mgmt_rdata[9:4] == PMR_ID_MODEL)
        else $error("identifier model field wrong");
    a_mask_reset: assert property (@(posedge clk) $past(!rst_n) |-> st_reg.mask == PMR_MASK_RESET) // see (R21)
        else $error("mask reset value wrong");
    a_adv_protect: assert property (@(posedge clk) disable iff (!rst_n) // see (R7)
        (st_reg.adv & ~PMR_ADV_WMASK) == (PMR_ADV_RESET & ~PMR_ADV_WMASK))
        else $error("unsupported advertisement bit set");
    a_cfg2_ones: assert property (@(posedge clk) disable iff (!rst_n) // see (R14)
        mgmt_rvalid && $past(mgmt_addr) == PMR_CONFIG_TWO |-> mgmt_rdata[15:8] == 8'hff)
        else $error("config two upper byte not ones");
    a_change_sets: assert property (@(posedge clk) disable iff (!rst_n) // see (R18)
        |changed[8:0] |=> st_reg.change) else $error("change flag not set");
    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n) // see (R24)
        st_reg.mask == 16'hffc0 && !st_reg.irq && !(|changed[8:0] && !st_reg.mask[15]) |=> !st_reg.irq)
        else $error("interrupt raised while masked");
    a_irq_clear: assert property (@(posedge clk) disable iff (!rst_n) // see (R24)
        rd_stat && !(|changed[8:0]) |=> !st_reg.irq) else $error("interrupt not dropped by read");
    a_pulse_gate: assert property (@(posedge clk) disable iff (!rst_n) // see (R17)
        !st_reg.cfg2[PMR_C2_IRQP] |-> !mgmt_line_irq_pulse) else $error("line pulse while disabled");
    a_speed_live: assert property (@(posedge clk) disable iff (!rst_n) // see (R20)
        stat_word[7] == speed_100) else $error("speed result mismatch");
    c_status_read: cover property (@(posedge clk) disable iff (!rst_n) rd_stat && st_reg.change);
    c_irq_raise:   cover property (@(posedge clk) disable iff (!rst_n) $rose(st_reg.irq));
    c_adv_write:   cover property (@(posedge clk) disable iff (!rst_n) wr_en && mgmt_addr == PMR_ADVERTISE);
    c_masked_evt:  cover property (@(posedge clk) disable iff (!rst_n) (|changed[8:0]) && st_reg.mask[15]);
    a_read_answer: assert property (@(posedge clk) disable iff (!rst_n) // see (R22)
        mgmt_valid && !mgmt_write |=> mgmt_rvalid) else $error("read not answered");
    a_clear_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see (R18)
        rd_stat && !(|changed[8:0]) && !(|(cond[8:2] & ~latched[8:2])) |=> !st_reg.change)
        else $error("change flag set by a read clear");
endmodule

// >>> pmr_pkg.sv
package pmr_pkg;

    // Register indices on the management interface.
    localparam logic [4:0] PMR_IDENT_HIGH   = 5'h02;
    localparam logic [4:0] PMR_IDENT_LOW    = 5'h03;
    localparam logic [4:0] PMR_ADVERTISE    = 5'h04;
    localparam logic [4:0] PMR_PARTNER      = 5'h05;
    localparam logic [4:0] PMR_CONFIG_ONE   = 5'h10;
    localparam logic [4:0] PMR_CONFIG_TWO   = 5'h11;
    localparam logic [4:0] PMR_EVENT_STATUS = 5'h12;
    localparam logic [4:0] PMR_EVENT_MASK   = 5'h13;
    localparam logic [4:0] PMR_FACTORY      = 5'h14;

    // Identifier values; the values are arbitrary.
    localparam logic [15:0] PMR_ID_HIGH_VAL = 16'h1234;
    localparam logic [5:0]  PMR_ID_OUI_VAL  = 6'h2a;
    localparam logic [5:0]  PMR_ID_MODEL    = 6'h15;
    localparam logic [3:0]  PMR_ID_REV      = 4'h1;

    // Reset values.
    localparam logic [15:0] PMR_ADV_RESET   = 16'h01e1;
    localparam logic [15:0] PMR_CFG1_RESET  = 16'h0022;
    localparam logic [15:0] PMR_CFG2_RESET  = 16'hff00;
    localparam logic [15:0] PMR_MASK_RESET  = 16'hffc0;
    localparam logic [15:0] PMR_FACT_RESET  = 16'h00a0;
    localparam logic [15:0] PMR_STAT_RESET  = 16'h0080;

    // Writable bits of each register.
    localparam logic [15:0] PMR_ADV_WMASK   = 16'ha1e1;
    localparam logic [15:0] PMR_CFG1_WMASK  = 16'he7ff;
    localparam logic [15:0] PMR_CFG2_WMASK  = 16'h003f;
    localparam logic [15:0] PMR_MASK_WMASK  = 16'hffc0;

    // Field positions.
    localparam int PMR_ADV_NP    = 15;
    localparam int PMR_ADV_ACK   = 14;
    localparam int PMR_ADV_RF    = 13;
    localparam int PMR_C1_LNKOFF = 15;
    localparam int PMR_C1_TXOFF  = 14;
    localparam int PMR_C1_TXSLP  = 13;
    localparam int PMR_C1_BYP    = 10;
    localparam int PMR_C1_IDLE   = 9;
    localparam int PMR_C1_EQOFF  = 8;
    localparam int PMR_C2_POLOFF = 5;
    localparam int PMR_C2_BABOFF = 4;
    localparam int PMR_C2_MULTI  = 3;
    localparam int PMR_C2_IRQP   = 2;
    localparam int PMR_ST_CHANGE = 15;

endpackage

// >>> pmr_event_latch.sv
`timescale 1ns/1ps
module pmr_event_latch (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [8:0]  cond,
    input  wire logic        rd_clear,
    output logic      [8:0]  latched
);
    typedef struct packed {
        logic [8:0] lat;
    } pmr_lat_s;

    pmr_lat_s st_reg;
    pmr_lat_s st_next;

    // A flag follows its condition, holds after an event, and clears on read only when the condition is gone.
    always_comb begin
        st_next = st_reg;
        if (rd_clear) begin
            st_next.lat = cond; // see (R23)
        end else begin
            st_next.lat = st_reg.lat | cond;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign latched = st_reg.lat;
endmodule

// >>> pmr_station.sv
`timescale 1ns/1ps
module pmr_station (
    input  wire logic        clk,
    input  wire logic        mgmt_rvalid,
    input  wire logic [15:0] mgmt_rdata,
    output logic             mgmt_valid,
    output logic             mgmt_write,
    output logic      [4:0]  mgmt_addr,
    output logic      [15:0] mgmt_wdata
);
    import pmr_pkg::*;

    // The management bus starts idle.
    initial begin
        mgmt_valid = 1'b0;
        mgmt_write = 1'b0;
        mgmt_addr  = 5'h00;
        mgmt_wdata = 16'h0000;
    end

    // One-cycle write strobe; stale lines are inverted once the strobe is gone.
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(negedge clk);
        mgmt_valid = 1'b1;
        mgmt_write = 1'b1;
        mgmt_addr  = a;
        mgmt_wdata = (a == PMR_CONFIG_ONE) ? (v & PMR_CFG1_WMASK) : v;
        @(negedge clk);
        mgmt_valid = 1'b0;
        mgmt_addr  = ~mgmt_addr;
        mgmt_wdata = ~mgmt_wdata;
    endtask

    // Read strobe, then a bounded wait for the answer pulse.
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        int n;
        @(negedge clk);
        mgmt_valid = 1'b1;
        mgmt_write = 1'b0;
        mgmt_addr  = a;
        @(negedge clk);
        mgmt_valid = 1'b0;
        mgmt_addr  = ~mgmt_addr;
        n = 0;
        while (mgmt_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        v = (mgmt_rvalid === 1'b1) ? mgmt_rdata : 16'hxxxx;
    endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import pmr_pkg::*;
    logic        clk, rst_n, mgmt_valid, mgmt_write, mgmt_rvalid, an_ack_in, an_partner_load;
    logic        speed_100, duplex_full, equalizer_on, mgmt_line_irq_pulse, irq_pending;
    logic [4:0]  mgmt_addr;
    logic [6:0]  ev;
    logic [10:0] ctl;
    logic [15:0] mgmt_wdata, mgmt_rdata, an_partner_word, adv_word, d;
    logic [15:0] sh [0:31];
    logic [4:0]  ra [0:9] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h10, 5'h11, 5'h13, 5'h14, 5'h1f, 5'h00};
    int          err_total, total_checks, seed, i, k;

    // Clock at 25 MHz.
    always #20 clk = ~clk;

    pmr_station u_pmr_station (.clk(clk), .mgmt_rvalid(mgmt_rvalid), .mgmt_rdata(mgmt_rdata),
        .mgmt_valid(mgmt_valid), .mgmt_write(mgmt_write), .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata));

    pmr_regs u_pmr_regs (
        .clk(clk), .rst_n(rst_n), .mgmt_valid(mgmt_valid), .mgmt_write(mgmt_write), .mgmt_addr(mgmt_addr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .an_ack_in(an_ack_in),
        .an_partner_load(an_partner_load), .an_partner_word(an_partner_word), .ev_link_lost(ev[6]),
        .ev_desc_unlocked(ev[5]), .ev_bad_code_group(ev[4]), .ev_start_delim_error(ev[3]),
        .ev_end_delim_error(ev[2]), .ev_polarity_flipped(ev[1]), .ev_babble_detect(ev[0]),
        .speed_100(speed_100), .duplex_full(duplex_full), .adv_word(adv_word),
        .next_page_request(ctl[10]), .remote_fault_adv(ctl[9]), .link_detect_off(ctl[8]), .tp_tx_off(ctl[7]),
        .tp_tx_sleep(ctl[6]), .scrambler_bypass(ctl[5]), .plain_idle_reject(ctl[4]), .equalizer_off(ctl[3]),
        .equalizer_on(equalizer_on), .polarity_fix_off(ctl[2]), .babble_check_off(ctl[1]),
        .multi_register_access(ctl[0]), .mgmt_line_irq_pulse(mgmt_line_irq_pulse), .irq_pending(irq_pending));

    // Writable bits of each register.
    function automatic logic [15:0] wm(input logic [4:0] a);
        case (a)
            PMR_ADVERTISE:  return PMR_ADV_WMASK;
            PMR_CONFIG_ONE: return PMR_CFG1_WMASK;
            PMR_CONFIG_TWO: return PMR_CFG2_WMASK;
            PMR_EVENT_MASK: return PMR_MASK_WMASK;
            PMR_FACTORY:    return 16'hffff;
            default:        return 16'h0000;
        endcase
    endfunction

    // Compares and counts one value.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Writes a register and keeps the shadow copy in step.
    task automatic put(input logic [4:0] a, input logic [15:0] v);
        u_pmr_station.wr(a, v);
        sh[a] = (sh[a] & ~wm(a)) | (v & wm(a));
    endtask

    // Reads a register and compares it with the shadow copy.
    task automatic look(input logic [4:0] a);
        u_pmr_station.rd(a, d);
        chk(d, (a == PMR_ADVERTISE) ? {sh[4][15], an_ack_in, sh[4][13:0]} : sh[a], "register");
    endtask

    // Holds an event condition for two cycles, then lets it settle.
    task automatic pulse(input logic [6:0] e);
        @(negedge clk);
        ev = e;
        repeat (2) @(negedge clk);
        ev = 7'h00;
        repeat (2) @(negedge clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cuts a hang short well after the tests should have ended.
    initial begin
        #800000;
        err_total++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        an_ack_in = 1'b0;
        an_partner_load = 1'b0;
        an_partner_word = 16'h0000;
        ev = 7'h00;
        speed_100 = 1'b1;
        duplex_full = 1'b0;
        seed = 22;
        err_total = 0;
        total_checks = 0;
        foreach (sh[k]) sh[k] = 16'h0000;
        sh[2] = PMR_ID_HIGH_VAL;
        sh[3] = {PMR_ID_OUI_VAL, PMR_ID_MODEL, PMR_ID_REV};
        sh[4] = PMR_ADV_RESET;
        sh[16] = PMR_CFG1_RESET;
        sh[17] = PMR_CFG2_RESET;
        sh[19] = PMR_MASK_RESET;
        sh[20] = PMR_FACT_RESET;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        foreach (ra[k]) look(ra[k]);
        u_pmr_station.rd(PMR_EVENT_STATUS, d);
        chk(d, PMR_STAT_RESET, "status reset");
        $display("Test reset values done");
        // Twelve random writes to places drawn from the sweep list, read-only ones too, then a full sweep.
        for (i = 0; i < 12; i++) begin
            k = $unsigned($random(seed)) % 10;
            put(ra[k], 16'($random(seed)));
        end
        put(PMR_ADVERTISE, 16'hffff);
        chk(16'(adv_word[9]), 16'h0000, "four pair refused");
        put(PMR_CONFIG_ONE, 16'hffff);
        foreach (ra[k]) look(ra[k]);
        d = 16'({sh[4][15], sh[4][13], sh[16][15:13], sh[16][10:8], sh[17][5:3]});
        chk(16'(ctl), d, "controls");
        chk(16'(equalizer_on), 16'(!sh[16][8] && speed_100), "equalizer");
        $display("Test random writes done");
        // Partner word capture and the acknowledge bit.
        @(negedge clk);
        an_ack_in = 1'b1;
        an_partner_word = 16'($random(seed));
        an_partner_load = 1'b1;
        @(negedge clk);
        an_partner_load = 1'b0;
        sh[5] = an_partner_word;
        look(PMR_PARTNER);
        look(PMR_ADVERTISE);
        chk(adv_word, {sh[4][15], 1'b1, sh[4][13:0]}, "advertised word");
        an_ack_in = 1'b0;
        $display("Test partner word done");
        // A masked event leaves the interrupt low.
        put(PMR_EVENT_MASK, 16'hffff);
        put(PMR_CONFIG_TWO, 16'h0004);
        u_pmr_station.rd(PMR_EVENT_STATUS, d);
        u_pmr_station.rd(PMR_EVENT_STATUS, d);
        pulse(7'h40);
        chk(16'({irq_pending, mgmt_line_irq_pulse}), 16'h0000, "masked event");
        u_pmr_station.rd(PMR_EVENT_STATUS, d);
        put(PMR_EVENT_MASK, 16'h0000);
        // Every event source in turn: latch, interrupt, clear on read.
        for (i = 0; i < 7; i++) begin
            pulse(7'(1 << i));
            chk(16'({irq_pending, mgmt_line_irq_pulse}), 16'h0003, "interrupt raised");
            u_pmr_station.rd(PMR_EVENT_STATUS, d);
            chk(d, {1'b1, 7'(1 << i), speed_100, duplex_full, 6'h00}, "latched event");
            u_pmr_station.rd(PMR_EVENT_STATUS, d);
            chk({d[15:8], 6'h00, irq_pending, 1'b0}, 16'h0000, "cleared event");
        end
        $display("Test events done");
        // Babble is ignored while its check is off.
        put(PMR_CONFIG_TWO, 16'h0010);
        pulse(7'h01);
        u_pmr_station.rd(PMR_EVENT_STATUS, d);
        chk(16'(d[8]), 16'h0000, "babble ignored");
        // Speed and duplex flags follow the live inputs; the equalizer runs only at the fast rate.
        put(PMR_CONFIG_ONE, 16'h0000);
        for (i = 0; i < 6; i++) begin
            @(negedge clk);
            {speed_100, duplex_full} = 2'($random(seed));
            u_pmr_station.rd(PMR_EVENT_STATUS, d);
            chk(16'(d[7:6]), 16'({speed_100, duplex_full}), "speed and duplex");
            chk(16'(equalizer_on), 16'(!sh[16][8] && speed_100), "equalizer on");
        end
        $display("Test speed and duplex done");
        // A reset in mid-run restores the defaults and leaves the identifier as it was.
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        look(PMR_IDENT_HIGH);
        look(PMR_IDENT_LOW);
        u_pmr_station.rd(PMR_EVENT_MASK, d);
        chk(d, PMR_MASK_RESET, "mask after reset");
        u_pmr_station.rd(PMR_CONFIG_ONE, d);
        chk(d, PMR_CFG1_RESET, "config one after reset");
        $display("Test mid-run reset done");
        give_verdict();
    end
endmodule
